// >>> core/sar_regs.svh
// constants for the serial converter control link and its host controller
`ifndef SAR_REGS_SVH
`define SAR_REGS_SVH
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define SAR_CLK_NS 8
`define SAR_SCLK_HALF_NS 200
`define SAR_SCLK_HALF_CYC ((`SAR_SCLK_HALF_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_DROOP_NS 1600000
`define SAR_DROOP_CYC (`SAR_DROOP_NS / `SAR_CLK_NS)
// -----------------------------------------------------------------
// control byte layout and framing
// -----------------------------------------------------------------
`define SAR_BIT_START 7
`define SAR_CH_MSB 6
`define SAR_CH_LSB 4
`define SAR_BIT_RES 3
`define SAR_BIT_CFG 2
`define SAR_PD_ON 2'b11
`define SAR_BYTE_LAST 3'h7
`define SAR_CNT_ACQ 3'h4
`define SAR_CNT_CFG 3'h5
`define SAR_RES_HI 5'hC
`define SAR_RES_LO 5'h8
`define SAR_IDX_BYTE2 5'h08
`define SAR_IDX_BYTE3 5'h10
`define SAR_IDX_LAST 5'h17
// -----------------------------------------------------------------
// host controller register map
// -----------------------------------------------------------------
`define SAR_OFF_CTRL 4'h0
`define SAR_OFF_STATUS 4'h4
`define SAR_OFF_RESULT 4'h8
`define SAR_OFF_GAP 4'hC
`define SAR_OFF_NONE 4'h1
`define SAR_CTRL_OVL 8
`define SAR_ST_BUSY 0
`define SAR_ST_PEND 1
`define SAR_ST_DONE 2
`define SAR_ST_PIN 3
`endif

// >>> core/sar_pkg.sv
// shared types of the serial converter link
package sar_pkg;
  typedef enum logic [2:0] {
    SAR_H_IDLE = 3'b001,
    SAR_H_RUN = 3'b010,
    SAR_H_PAUSE = 3'b100
  } sar_host_st_t;
endpackage

// >>> core/sar_link_if.sv
// five-wire serial link between host controller and converter logic
`timescale 1ns/100ps
interface sar_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout_d;
  logic dout_oe_n;
  logic busy_d;
  logic busy_oe_n;
  logic dout;
  logic busy;
  // ---------------------------------------------------------------
  // wire resolution: undriven lines read low (weak pull-down)
  // ---------------------------------------------------------------
  assign dout = dout_oe_n ? 1'b0 : dout_d;
  assign busy = busy_oe_n ? 1'b0 : busy_d;
  modport dev (input sclk, input cs_n, input din,
    output dout_d, output dout_oe_n, output busy_d, output busy_oe_n);
  modport host (output sclk, output cs_n, output din, input dout, input busy);
endinterface

// >>> core/sar_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
module sar_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= RST;
      q_o <= RST;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// >>> core/sar_dev.sv
// converter-side serial control and conversion sequencing
// Notes on behaviour
// - transfers are eight clocks, conversion 24
// - host sends control byte in first eight clocks
// - mux set, acquisition starts once channel known
// - three clocks later hold and convert
// - twelve conversion clocks plus one for last bit
// - padding clocks ignored, output driven low
// - ignore input until first high start bit
// - host sends start bit high, first
// - bits 6-4 channel select, MSB first
// - new byte every 15th or 11th clock
// - bit 3 picks 8 bits only if pin high
// - bit 2 high single-ended, low differential
// - power bits: 00 auto-off, 11 always on
// - wake instantly, first result valid
// - next byte may overlap result, 16 clocks
// - host finishes conversion within 1.6 ms; the host starts no pause after 0.8 ms but never cuts one short
// - stay powered through pauses between bytes
// - channel patterns map single and differential pairs
// - input sampled rising, output changed falling
// - results are unsigned straight binary
// - shutdown low forces power-down at once
`timescale 1ns/100ps
`include "sar_regs.svh"
module sar_dev
  import sar_pkg::*;
#(
  parameter int RES_W = 12
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  sar_link_if.dev lnk,
  input wire logic [RES_W-1:0] sample_code_i,
  input wire logic resolution_enable_i,
  input wire logic shutdown_n_i,
  output logic [3:0] mux_pos_o,
  output logic [4:0] mux_neg_o,
  output logic acquire_o,
  output logic hold_o,
  output logic powered_o
);
  // -----------------------------------------------------------------
  // pin synchronisation and edge detection
  // -----------------------------------------------------------------
  logic sclk_s;
  logic cs_s;
  logic din_s;
  logic shutdown_n_n_s;
  logic resen_s;
  logic sclk_q;
  logic rise;
  logic fall;

  // every pin arrives from outside the clock domain
  sar_sync #(.W(5), .RST(5'b01010)) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i({lnk.sclk, lnk.cs_n, lnk.din, shutdown_n_i, resolution_enable_i}),
    .q_o({sclk_s, cs_s, din_s, shutdown_n_n_s, resen_s})
  );

  // edge detector looks at the second stage only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
    end
  end

  // clock edges count only inside a frame
  assign rise = sclk_s & ~sclk_q & ~cs_s;
  assign fall = ~sclk_s & sclk_q & ~cs_s;

  // -----------------------------------------------------------------
  // control byte receiver
  // -----------------------------------------------------------------
  logic rx_act_reg;
  logic [2:0] rx_cnt_reg;
  logic [6:0] rx_sh_reg;
  logic acq_pt;
  logic cfg_pt;
  logic byte_done;

  assign acq_pt = rise & rx_act_reg & (rx_cnt_reg == `SAR_CNT_ACQ);
  assign cfg_pt = rise & rx_act_reg & (rx_cnt_reg == `SAR_CNT_CFG);
  assign byte_done = rise & rx_act_reg & (rx_cnt_reg == `SAR_BYTE_LAST);

  // hunts for the start bit whenever no byte is in flight, so the next
  // byte may arrive while a result is still shifting out
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_act_reg <= 1'b0;
      rx_cnt_reg <= 3'h0;
      rx_sh_reg <= 7'h00;
    end else if (cs_s) begin
      rx_act_reg <= 1'b0;
      rx_cnt_reg <= 3'h0;
    end else if (rise) begin
      if (!rx_act_reg) begin
        if (din_s) begin
          rx_act_reg <= 1'b1;
          rx_cnt_reg <= 3'h1;
        end
      end else begin
        rx_sh_reg <= {rx_sh_reg[5:0], din_s};
        rx_cnt_reg <= rx_cnt_reg + 3'h1;
        if (rx_cnt_reg == `SAR_BYTE_LAST) begin
          rx_act_reg <= 1'b0;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // latched control fields
  // -----------------------------------------------------------------
  logic [2:0] channel_select_reg;
  logic input_config_select_reg;
  logic res_bit_reg;
  logic [1:0] power_select_reg;
  logic eight_reg;
  logic [RES_W-1:0] code_reg;

  // channel latches on the fifth bit, config on its own bit, resolution and power with the last bit
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      channel_select_reg <= 3'h0;
      input_config_select_reg <= 1'b0;
      res_bit_reg <= 1'b0;
      power_select_reg <= 2'b00;
      eight_reg <= 1'b0;
      code_reg <= '0;
    end else begin
      if (acq_pt) begin
        channel_select_reg <= rx_sh_reg[2:0];
      end
      if (cfg_pt) begin
        input_config_select_reg <= din_s;
      end
      if (byte_done) begin
        res_bit_reg <= rx_sh_reg[2];
        power_select_reg <= {rx_sh_reg[0], din_s};
        eight_reg <= rx_sh_reg[2] & resen_s;
        code_reg <= sample_code_i;
      end
    end
  end

  // -----------------------------------------------------------------
  // multiplexer decode
  // -----------------------------------------------------------------
  // returns {negative side incl. common at bit 4, positive side}
  function automatic logic [8:0] mux_decode(input logic [2:0] ch, input logic sgl);
    logic [8:0] r;
    r = 9'h000;
    unique case (ch)
      3'b001: r = sgl ? {5'b10000, 4'b0001} : {5'b00010, 4'b0001};
      3'b101: r = sgl ? {5'b10000, 4'b0010} : {5'b00001, 4'b0010};
      3'b010: r = sgl ? {5'b10000, 4'b0100} : {5'b01000, 4'b0100};
      3'b110: r = sgl ? {5'b10000, 4'b1000} : {5'b00100, 4'b1000};
      default: r = 9'h000; // unlisted patterns leave the switches open
    endcase
    return r;
  endfunction

  logic [8:0] mux_sel;
  assign mux_sel = mux_decode(channel_select_reg, input_config_select_reg);

  // -----------------------------------------------------------------
  // acquisition and hold
  // -----------------------------------------------------------------
  logic acq_reg;
  logic hold_reg;
  logic conv_arm_reg;
  logic conv_reg;
  logic [4:0] fcnt_reg;
  logic [RES_W-1:0] out_sh_reg;
  logic dout_reg;
  logic busy_reg;
  logic [4:0] nbits;

  assign nbits = eight_reg ? `SAR_RES_LO : `SAR_RES_HI;

  // sampling opens on the fifth bit and closes with the byte
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acq_reg <= 1'b0;
    end else if (cs_s) begin
      acq_reg <= 1'b0;
    end else if (acq_pt) begin
      acq_reg <= 1'b1;
    end else if (byte_done) begin
      acq_reg <= 1'b0;
    end
  end

  // hold covers the whole bit decision phase
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_reg <= 1'b0;
      conv_arm_reg <= 1'b0;
    end else if (cs_s) begin
      hold_reg <= 1'b0;
      conv_arm_reg <= 1'b0;
    end else if (byte_done) begin
      hold_reg <= 1'b1;
      conv_arm_reg <= 1'b1;
    end else begin
      if (fall && conv_arm_reg) begin
        conv_arm_reg <= 1'b0;
      end
      if (fall && conv_reg && fcnt_reg == nbits + 5'h1) begin
        hold_reg <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // result shifter on falling clock edges
  // -----------------------------------------------------------------
  // first falling edge after hold raises busy, then one bit per edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conv_reg <= 1'b0;
      fcnt_reg <= 5'h0;
      out_sh_reg <= '0;
      dout_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else if (cs_s) begin
      conv_reg <= 1'b0; // aborting mid-result is the cost of a cheap restart
      fcnt_reg <= 5'h0;
      dout_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else if (fall) begin
      if (conv_arm_reg) begin
        conv_reg <= 1'b1;
        fcnt_reg <= 5'h1;
        busy_reg <= 1'b1;
        dout_reg <= 1'b0;
        out_sh_reg <= eight_reg ? {code_reg[RES_W-1:RES_W-8], {(RES_W-8){1'b0}}} : code_reg;
      end else if (conv_reg && fcnt_reg <= nbits) begin
        busy_reg <= 1'b0;
        dout_reg <= out_sh_reg[RES_W-1];
        out_sh_reg <= {out_sh_reg[RES_W-2:0], 1'b0};
        fcnt_reg <= fcnt_reg + 5'h1;
      end else begin
        conv_reg <= 1'b0;
        dout_reg <= 1'b0;
        busy_reg <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // power state
  // -----------------------------------------------------------------
  // power bits 11 or activity keep power up, independent of clock pauses
  assign powered_o = shutdown_n_n_s & ((power_select_reg == `SAR_PD_ON) | acq_reg | hold_reg);

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign acquire_o = acq_reg & shutdown_n_n_s;
  assign hold_o = hold_reg & shutdown_n_n_s;
  assign mux_pos_o = (acq_reg | hold_reg) ? mux_sel[3:0] : 4'h0;
  assign mux_neg_o = (acq_reg | hold_reg) ? mux_sel[8:4] : 5'h00;
  // both outputs float whenever the frame is closed
  assign lnk.dout_d = dout_reg;
  assign lnk.busy_d = busy_reg;
  assign lnk.dout_oe_n = cs_s;
  assign lnk.busy_oe_n = cs_s;
endmodule

// >>> core/sar_host.sv
// host-side serial controller with an AHB-Lite register slave
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "sar_regs.svh"
module sar_host
  import sar_pkg::*;
#(
  parameter int HALF_CYC = `SAR_SCLK_HALF_CYC,
  parameter int DROOP_CYC = `SAR_DROOP_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  sar_link_if.host lnk
);
  // -----------------------------------------------------------------
  // pins and registers
  // -----------------------------------------------------------------
  logic dout_s;
  logic busy_s;
  logic wr_q;
  logic [3:0] wa_q;
  logic [7:0] ctrl_reg;
  logic ovl_reg;
  logic pend_reg;
  logic done_reg;
  logic [11:0] result_reg;
  logic [15:0] gap_reg;
  logic take;
  logic res_set;
  logic acc;
  logic [3:0] roff;
  sar_host_st_t st_reg;

  sar_sync #(.W(2), .RST(2'b00)) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i({lnk.dout, lnk.busy}),
    .q_o({dout_s, busy_s})
  );

  // zero-wait slave: every transfer completes in its first data phase
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign acc = hsel_i & hready_i & htrans_i[1];
  // offsets above the map decode to an unused code, so they never alias a register
  assign roff = (haddr_i[31:4] == 28'h0) ? haddr_i[3:0] : `SAR_OFF_NONE;

  // read data is prepared in the address phase
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_q <= 1'b0;
      wa_q <= 4'h0;
      hrdata_o <= 32'h0000_0000;
    end else begin
      wr_q <= acc & hwrite_i;
      wa_q <= roff;
      if (acc && !hwrite_i) begin
        unique case (roff)
          `SAR_OFF_CTRL: hrdata_o <= {23'h0, ovl_reg, ctrl_reg};
          `SAR_OFF_STATUS: hrdata_o <= {28'h0, busy_s, done_reg, pend_reg, st_reg != SAR_H_IDLE};
          `SAR_OFF_RESULT: hrdata_o <= {20'h0, result_reg};
          `SAR_OFF_GAP: hrdata_o <= {16'h0, gap_reg};
          default: hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // command and setup registers; a new command sets pending, set wins
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg <= 8'h80;
      ovl_reg <= 1'b0;
      pend_reg <= 1'b0;
      gap_reg <= 16'h0000;
    end else begin
      if (wr_q && wa_q == `SAR_OFF_CTRL) begin
        ctrl_reg <= {1'b1, hwdata_i[6:0]};
        ovl_reg <= hwdata_i[`SAR_CTRL_OVL];
        pend_reg <= 1'b1;
      end else if (take) begin
        pend_reg <= 1'b0;
      end
      if (wr_q && wa_q == `SAR_OFF_GAP) begin
        gap_reg <= hwdata_i[15:0];
      end
    end
  end

  // done flag: a fresh result beats the clearing read
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done_reg <= 1'b0;
    end else if (res_set) begin
      done_reg <= 1'b1;
    end else if (acc && !hwrite_i && roff == `SAR_OFF_RESULT) begin
      done_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // frame sequencer
  // -----------------------------------------------------------------
  logic [15:0] div_reg;
  logic tick;
  logic sclk_reg;
  logic cs_n_reg;
  logic din_reg;
  logic [4:0] idx_reg;
  logic [4:0] idx_nx;
  logic [7:0] cur_reg;
  logic ov_reg;
  logic [15:0] samp_reg;
  logic [15:0] gcnt_reg;
  logic [31:0] elap_reg;
  logic fall_ev;
  logic may_pause;

  assign tick = (st_reg != SAR_H_IDLE) && (div_reg == 16'(HALF_CYC - 1));
  assign fall_ev = (st_reg == SAR_H_RUN) && tick && sclk_reg;
  assign idx_nx = idx_reg + 5'h1;
  // without overlap a queued command stays pending until the sequencer is idle
  assign take = ((st_reg == SAR_H_IDLE) && pend_reg) || (fall_ev && idx_nx == `SAR_IDX_BYTE3 && ovl_reg);
  assign res_set = fall_ev && idx_reg == `SAR_IDX_LAST;
  // pauses stop once half the droop budget is spent
  assign may_pause = (gap_reg != 16'h0000) && (elap_reg < 32'(DROOP_CYC / 2));

  // half-period divider of the shift clock
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_reg <= 16'h0000;
    end else if (st_reg == SAR_H_IDLE || tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // time since hold, for the droop budget
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      elap_reg <= 32'h0;
    end else if (fall_ev && (idx_nx == `SAR_IDX_BYTE2 || idx_reg == `SAR_IDX_LAST)) begin
      elap_reg <= 32'h0;
    end else if (elap_reg != 32'hFFFF_FFFF) begin
      elap_reg <= elap_reg + 32'h1;
    end
  end

  // din follows the bit position, changing only while sclk is low
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      din_reg <= 1'b0;
    end else if (!sclk_reg) begin
      din_reg <= (idx_reg < `SAR_IDX_BYTE2 || (ov_reg && idx_reg >= `SAR_IDX_BYTE3)) ?
        cur_reg[~idx_reg[2:0]] : 1'b0;
    end
  end

  // three byte transfers per conversion, or the 16-clock loop when overlapped
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= SAR_H_IDLE;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      idx_reg <= 5'h00;
      cur_reg <= 8'h80;
      ov_reg <= 1'b0;
      samp_reg <= 16'h0000;
      gcnt_reg <= 16'h0000;
      result_reg <= 12'h000;
    end else begin
      unique case (st_reg)
        SAR_H_IDLE: begin
          if (pend_reg) begin
            st_reg <= SAR_H_RUN;
            cs_n_reg <= 1'b0;
            cur_reg <= ctrl_reg;
            idx_reg <= 5'h00;
            ov_reg <= 1'b0;
          end
        end
        SAR_H_RUN: begin
          if (tick && !sclk_reg) begin
            sclk_reg <= 1'b1;
            if (idx_reg >= `SAR_IDX_BYTE2) begin
              samp_reg <= {samp_reg[14:0], dout_s};
            end
          end else if (tick) begin
            sclk_reg <= 1'b0;
            if (idx_reg == `SAR_IDX_LAST) begin
              result_reg <= samp_reg[14:3];
              if (ov_reg) begin
                idx_reg <= `SAR_IDX_BYTE2;
                ov_reg <= 1'b0;
              end else begin
                st_reg <= SAR_H_IDLE;
                cs_n_reg <= 1'b1;
              end
            end else begin
              idx_reg <= idx_nx;
              if (idx_nx == `SAR_IDX_BYTE3) begin
                cur_reg <= ctrl_reg;
                ov_reg <= pend_reg & ovl_reg;
              end
              if ((idx_nx == `SAR_IDX_BYTE2 || idx_nx == `SAR_IDX_BYTE3) && may_pause) begin
                st_reg <= SAR_H_PAUSE;
                gcnt_reg <= gap_reg;
              end
            end
          end
        end
        SAR_H_PAUSE: begin
          if (tick) begin
            gcnt_reg <= gcnt_reg - 16'h0001;
            if (gcnt_reg == 16'h0001) begin
              st_reg <= SAR_H_RUN;
            end
          end
        end
      endcase
    end
  end

  assign lnk.sclk = sclk_reg;
  assign lnk.cs_n = cs_n_reg;
  assign lnk.din = din_reg;
endmodule

// >>> verif/sar_link_chk.sv
// serial link checker, watches the wires between host and converter
`timescale 1ns/100ps
module sar_link_chk #(
  parameter int HALF_CYC = 25
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout_d,
  input wire logic dout_oe_n,
  input wire logic busy_d,
  input wire logic busy_oe_n
);
  logic sclk_q;
  logic [7:0] rise_cnt;
  logic [15:0] busy_cnt;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // ----------
  // helpers
  // ----------
  // last clock level, for rise detection
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end
  // rises within one frame; wraps, only the low bits matter
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rise_cnt <= 8'h00;
    else if (cs_n) rise_cnt <= 8'h00;
    else if (sclk && !sclk_q) rise_cnt <= rise_cnt + 8'h01;
  end
  // length of the busy pulse in system clocks
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) busy_cnt <= 16'h0000;
    else if (busy_d) busy_cnt <= busy_cnt + 16'h0001;
    else busy_cnt <= 16'h0000;
  end
  // ----------
  // properties
  // ----------
  a_dout_released: assert property (cs_n [*4] |-> dout_oe_n)
    else $error("data line driven while deselected");
  a_busy_released: assert property (cs_n [*4] |-> busy_oe_n)
    else $error("busy line driven while deselected");
  a_dout_driven: assert property ((!cs_n) [*4] |-> !dout_oe_n)
    else $error("data line not driven in frame");
  a_dout_on_fall: assert property (!dout_oe_n && $changed(dout_d) |-> !sclk)
    else $error("data changed while clock high");
  a_busy_on_fall: assert property ($rose(busy_d) |-> !sclk && !cs_n)
    else $error("busy rose outside a low clock phase");
  a_busy_width: assert property ($fell(busy_d) |-> busy_cnt == 16'(2 * HALF_CYC))
    else $error("busy pulse not one clock period");
  a_din_steady: assert property (sclk && sclk_q |-> $stable(din))
    else $error("input changed while clock high");
  a_clock_framed: assert property (sclk |-> !cs_n)
    else $error("clock runs outside a frame");
  a_frame_bytes: assert property ($rose(cs_n) |-> rise_cnt[2:0] == 3'h0)
    else $error("frame not whole bytes");
  c_busy: cover property ($fell(busy_d));
  c_frame: cover property ($rose(cs_n));
  c_data_high: cover property (dout_d && !dout_oe_n);
endmodule

// >>> verif/tb_sar_adc_serial_control.sv
// bench for host controller and converter joined over the serial link
`timescale 1ns/100ps
module tb_sar_adc_serial_control;
  typedef struct packed {
    logic [7:0] ctrl;
    logic pin;
    logic [11:0] code;
    logic [3:0] pos;
    logic [4:0] neg;
    logic [11:0] res;
  } sar_row_t;
  localparam int HALF = 25;
  // control byte, mode pin, sample, expected mux and result
  sar_row_t rows [8] = '{
    '{8'h97, 1'b0, 12'hFFF, 4'h1, 5'h10, 12'hFFF},
    '{8'hDC, 1'b0, 12'hA5A, 4'h2, 5'h10, 12'hA5A},
    '{8'hAF, 1'b1, 12'h3C7, 4'h4, 5'h10, 12'h3C0},
    '{8'hE4, 1'b1, 12'h000, 4'h8, 5'h10, 12'h000},
    '{8'h93, 1'b0, 12'h800, 4'h1, 5'h02, 12'h800},
    '{8'hD8, 1'b1, 12'h7FF, 4'h2, 5'h01, 12'h7F0},
    '{8'hA0, 1'b0, 12'h001, 4'h4, 5'h08, 12'h001},
    '{8'hE3, 1'b0, 12'h555, 4'h8, 5'h04, 12'h555}
  };
  logic clk_i, arst_n_i, hsel, hwrite, hready, hresp, res_pin, shutdown_n;
  logic acquire, hold, powered;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [11:0] code;
  logic [3:0] mux_pos, mp;
  logic [4:0] mux_neg, mn;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int rises = 0;
  int csf[$], csr[$], acq[$], hld[$];
  sar_link_if sar_link_if_inst ();
  sar_host #(.HALF_CYC(HALF)) sar_host_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .lnk(sar_link_if_inst.host));
  sar_dev sar_dev_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .lnk(sar_link_if_inst.dev),
    .sample_code_i(code), .resolution_enable_i(res_pin), .shutdown_n_i(shutdown_n),
    .mux_pos_o(mux_pos), .mux_neg_o(mux_neg), .acquire_o(acquire), .hold_o(hold), .powered_o(powered));
  sar_link_chk #(.HALF_CYC(HALF)) sar_link_chk_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .sclk(sar_link_if_inst.sclk), .cs_n(sar_link_if_inst.cs_n), .din(sar_link_if_inst.din),
    .dout_d(sar_link_if_inst.dout_d), .dout_oe_n(sar_link_if_inst.dout_oe_n),
    .busy_d(sar_link_if_inst.busy_d), .busy_oe_n(sar_link_if_inst.busy_oe_n));
  // ----------
  // clock, timeout, edge stamps
  // ----------
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // a hung handshake ends the run as a failure
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      stop_test();
    end
  end
  // shift clock rises, stamped at frame and phase edges
  always @(posedge sar_link_if_inst.sclk) rises <= rises + 1;
  always @(negedge sar_link_if_inst.cs_n) if (arst_n_i === 1'b1) csf.push_back(rises);
  always @(posedge sar_link_if_inst.cs_n) if (arst_n_i === 1'b1) csr.push_back(rises);
  always @(posedge acquire) if (arst_n_i === 1'b1) acq.push_back(rises);
  always @(posedge hold) if (arst_n_i === 1'b1) hld.push_back(rises);
  // ----------
  // tasks
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // single word transfer, address held until ready, data phase after
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0, v);
    chk(v, exp);
  endtask
  task automatic wait_st(input logic [31:0] mask, input logic [31:0] want);
    ahb(1'b0, 32'h4, 32'h0, v);
    while ((v & mask) !== want) ahb(1'b0, 32'h4, 32'h0, v);
  endtask
  task automatic stop_test();
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // main sequence: reset, table, overlap, shutdown
  initial begin
    arst_n_i = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {code, res_pin, shutdown_n} = 14'h0001;
    repeat (10) @(posedge clk_i);
    chk({28'h0, sar_link_if_inst.sclk, sar_link_if_inst.cs_n, sar_link_if_inst.dout,
      sar_link_if_inst.busy}, 32'h4);
    chk({31'h0, powered}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    arst_n_i <= 1'b1;
    rd_chk(32'h0, 32'h80);
    rd_chk(32'h8, 32'h0);
    ahb(1'b1, 32'h10, 32'hFFFFFFFF, v);
    rd_chk(32'h10, 32'h0);
    ahb(1'b1, 32'hC, 32'hFFFFFFFF, v);
    rd_chk(32'hC, 32'h0000FFFF);
    ahb(1'b1, 32'hC, 32'h0, v);
    foreach (rows[i]) begin
      code <= rows[i].code;
      res_pin <= rows[i].pin;
      ahb(1'b1, 32'h0, {24'h0, rows[i].ctrl}, v);
      mp = 'x;
      mn = 'x;
      // keep the last mux setting seen while acquiring
      while (hold !== 1'b1) begin
        if (acquire === 1'b1) {mp, mn} = {mux_pos, mux_neg};
        @(posedge clk_i);
      end
      chk({28'h0, mp}, {28'h0, rows[i].pos});
      chk({27'h0, mn}, {27'h0, rows[i].neg});
      chk({31'h0, powered}, 32'h1);
      wait_st(32'h4, 32'h4);
      while (hold !== 1'b0) @(posedge clk_i);
      chk({31'h0, powered}, {31'h0, &rows[i].ctrl[1:0]});
      rd_chk(32'h8, {20'h0, rows[i].res});
      rd_chk(32'h4, 32'h0);
    end
    // two queued commands with overlap: next byte rides on the result
    ahb(1'b1, 32'h0, 32'h197, v);
    ahb(1'b1, 32'h0, 32'h197, v);
    wait_st(32'h7, 32'h4);
    chk(32'(hld[9] - hld[8]), 32'h10);
    rd_chk(32'h8, 32'h555);
    // a command queued without overlap still runs, in a frame of its own
    ahb(1'b1, 32'h0, 32'h97, v);
    ahb(1'b1, 32'h0, 32'h97, v);
    wait_st(32'h7, 32'h4);
    chk(32'(csf.size()), 32'hB);
    foreach (rows[i]) begin
      chk(32'(csr[i] - csf[i]), 32'h18);
      chk(32'(acq[i] - csf[i]), 32'h5);
      chk(32'(hld[i] - acq[i]), 32'h3);
    end
    chk({31'h0, powered}, 32'h1);
    shutdown_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({31'h0, powered}, 32'h0);
    shutdown_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, powered}, 32'h1);
    stop_test();
  end
endmodule
